// *** design/ufbc_regs.svh ***
// Overview of operation
// - block is 64 sectors, 33 pages, 128 bytes
// - one controller per 2 Mbit block
// - data port is 8, 16 or 32 bits
// - page buffer of 8 blocks stages programming
// - block buffer serves reads of last block
// - check bits correct single, detect double errors
// - random read 60 ns, read-ahead 10 ns
// - protected sectors or whole block refuse changes
// - serial port loads, decrypts, then programs
// - flash control timing counts 25 ns mclk_i cycles
`ifndef UFBC_REGS_SVH
`define UFBC_REGS_SVH
// geometry
`define UFBC_PAGE_BYTES 128
`define UFBC_PAGES_PER_SEC 33
`define UFBC_SECTORS 64
`define UFBC_NPAGES (`UFBC_PAGES_PER_SEC * `UFBC_SECTORS)
`define UFBC_BLK_PER_PAGE 8
`define UFBC_BLK_BITS 128
`define UFBC_CHK_BITS 9
`define UFBC_NBLK (`UFBC_NPAGES * `UFBC_BLK_PER_PAGE)
// address field positions
`define UFBC_PAGE_LSB 7
`define UFBC_BLK_LSB 4
// timing
`define UFBC_CLK_NS 25
`define UFBC_T_RAND_NS 60
`define UFBC_T_AHEAD_NS 10
`define UFBC_OSC_MHZ 100
`define UFBC_RAND_CYC ((`UFBC_T_RAND_NS + `UFBC_CLK_NS - 1) / `UFBC_CLK_NS)
`define UFBC_AHEAD_CYC ((`UFBC_T_AHEAD_NS / `UFBC_CLK_NS) > 0 ? \
    (`UFBC_T_AHEAD_NS / `UFBC_CLK_NS) : 1)
// reset values
`define UFBC_ERASED 1'b1
`define UFBC_KEY_RST 32'h5A3C_96E1
`endif

// *** design/ufbc_pkg.sv ***
package ufbc_pkg;
`include "ufbc_regs.svh"
    // controller states
    typedef enum logic [1:0] {
        UFBC_IDLE = 2'b00,
        UFBC_RWAIT = 2'b01,
        UFBC_PROG = 2'b10
    } ufbc_state_t;
    // configured data port width
    typedef enum logic [1:0] {
        UFBC_W8 = 2'b00,
        UFBC_W16 = 2'b01,
        UFBC_W32 = 2'b10
    } ufbc_width_t;
    // parallel port commands
    typedef enum logic [1:0] {
        UFBC_NOP = 2'b00,
        UFBC_READ = 2'b01,
        UFBC_WRITE = 2'b10,
        UFBC_PROGRAM = 2'b11
    } ufbc_cmd_t;
    // whole controller state
    typedef struct packed {
        ufbc_state_t st;
        logic [1:0] cnt;
        logic [31:0] rdata;
        logic ack;
        logic sec;
        logic ded;
        logic perr;
        logic busy;
        logic bb_valid;
        logic [14:0] bb_tag;
        logic [127:0] bb_data;
        logic [11:0] pb_page;
        logic [1023:0] pb;
        logic [2:0] pidx;
        logic [31:0] jsr;
        logic [4:0] jptr;
        logic [31:0] ks;
        logic [14:0] rblk;
        logic [3:0] roff;
    } ufbc_regs_t;
endpackage

// *** design/ufbc_top.sv ***
`timescale 1ns/1ps
module ufbc_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input ufbc_pkg::ufbc_width_t cfg_width_i,
    input wire logic ahead_en_i,
    input wire logic prot_all_i,
    input wire logic [63:0] prot_sec_i,
    input wire logic req_i,
    input ufbc_pkg::ufbc_cmd_t cmd_i,
    input wire logic [18:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic jtag_tdi_i,
    input wire logic jtag_shift_i,
    input wire logic jtag_load_i,
    input wire logic jtag_enc_i,
    input wire logic [11:0] jtag_page_i,
    input wire logic jtag_prog_i,
    output logic [31:0] rdata_o,
    output logic ack_o,
    output logic sec_o,
    output logic ded_o,
    output logic perr_o,
    output logic busy_o
);
    import ufbc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // check bits: hamming over positions 1..136 plus overall parity
    function automatic logic [8:0] ufbc_gen(input logic [127:0] d);
        logic [7:0] syn;
        int k;
        syn = 8'h00;
        k = 0;
        for (int p = 1; p < 137; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[k]) syn ^= 8'(p);
                k++;
            end
        end
        return {^d ^ ^syn, syn};
    endfunction

    // returns {sec, ded, corrected data}
    function automatic logic [129:0] ufbc_dec(input logic [136:0] w);
        logic [127:0] d;
        logic [7:0] syn;
        logic odd;
        logic [8:0] chk; // check bits regenerated from the data
        int k;
        d = w[127:0];
        chk = ufbc_gen(d);
        syn = w[135:128] ^ chk[7:0];
        odd = ^w;
        k = 0;
        for (int p = 1; p < 137; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (odd && syn == 8'(p)) d[k] = ~d[k];
                k++;
            end
        end
        return {odd, (syn != 8'h00) && !odd, d};
    endfunction

    // lane of a block for the configured width
    function automatic logic [31:0] ufbc_lane(input logic [127:0] b,
        input logic [3:0] off, input ufbc_width_t w);
        unique case (w)
            UFBC_W8: return {24'h00_0000, b[{off, 3'b000} +: 8]};
            UFBC_W16: return {16'h0000, b[{off[3:1], 4'h0} +: 16]};
            default: return b[{off[3:2], 5'h00} +: 32];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    ufbc_regs_t s; // registered state
    ufbc_regs_t next_s; // next state
    // data and check bits per block, one whole flash block
    logic [136:0] mem [0:`UFBC_NBLK-1];
    logic [136:0] rd_word; // array word being read
    logic [129:0] dec; // decoded read word
    logic [11:0] a_page; // page of the request
    logic [5:0] a_sec; // sector of the request
    logic [5:0] pb_sec; // sector of the buffered page
    logic [14:0] a_blk; // block of the request
    logic in_range; // request address inside the block
    logic acc; // request accepted this cycle
    logic hit; // request falls in the block buffer
    logic a_prot; // request sector protected
    logic pb_prot; // buffered page protected
    logic [31:0] jword; // serial word after decryption
    logic [9:0] wbit; // first page buffer bit of a write

    ////////////////////////////////////////////////////////////////////
    // address decode from the page and sector geometry
    always_comb begin
        a_page = addr_i[18:`UFBC_PAGE_LSB];
        a_blk = addr_i[18:`UFBC_BLK_LSB];
        in_range = a_page < 12'(`UFBC_NPAGES);
        a_sec = 6'(a_page / 12'(`UFBC_PAGES_PER_SEC));
        pb_sec = 6'(s.pb_page / 12'(`UFBC_PAGES_PER_SEC));
        a_prot = prot_all_i | prot_sec_i[a_sec];
        pb_prot = prot_all_i | prot_sec_i[pb_sec];
        acc = ce_i && req_i && s.st == UFBC_IDLE && cmd_i != UFBC_NOP;
        hit = s.bb_valid && s.bb_tag == a_blk;
        rd_word = mem[s.rblk];
        dec = ufbc_dec(rd_word);
        // keyed keystream removes the stream encryption
        jword = jtag_enc_i ? (s.jsr ^ s.ks) : s.jsr;
        unique case (cfg_width_i)
            UFBC_W8: wbit = {addr_i[6:0], 3'b000};
            UFBC_W16: wbit = {addr_i[6:1], 4'h0};
            default: wbit = {addr_i[6:2], 5'h00};
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.sec = 1'b0;
        next_s.ded = 1'b0;
        next_s.perr = 1'b0;
        // serial path: shift, then load decrypted words
        if (jtag_shift_i) next_s.jsr = {s.jsr[30:0], jtag_tdi_i};
        if (jtag_load_i && s.st == UFBC_IDLE) begin
            if (s.jptr == 5'h00) begin
                next_s.pb_page = jtag_page_i;
                next_s.pb = '1;
                next_s.ks = `UFBC_KEY_RST ^ {s.ks[30:0],
                    s.ks[31] ^ s.ks[21] ^ s.ks[1] ^ s.ks[0]};
                next_s.pb[31:0] = jtag_enc_i ?
                    (s.jsr ^ `UFBC_KEY_RST) : s.jsr;
            end else begin
                next_s.ks = {s.ks[30:0],
                    s.ks[31] ^ s.ks[21] ^ s.ks[1] ^ s.ks[0]};
                next_s.pb[{s.jptr, 5'h00} +: 32] = jword;
            end
            next_s.jptr = 5'(s.jptr + 5'h01);
        end
        unique case (s.st)
            UFBC_IDLE: begin
                if (acc && cmd_i != UFBC_PROGRAM && !in_range) begin
                    next_s.perr = 1'b1;
                    next_s.ack = 1'b1;
                end else if (acc && cmd_i == UFBC_READ) begin
                    if (ahead_en_i && hit) begin
                        // read-ahead: served from the buffer, no wait
                        next_s.rdata = ufbc_lane(s.bb_data, addr_i[3:0],
                            cfg_width_i);
                        next_s.ack = 1'b1;
                    end else begin
                        next_s.st = UFBC_RWAIT;
                        next_s.busy = 1'b1;
                        next_s.cnt = 2'(`UFBC_RAND_CYC - 2);
                        next_s.rblk = a_blk;
                        next_s.roff = addr_i[3:0];
                    end
                end else if (acc && cmd_i == UFBC_WRITE) begin
                    next_s.ack = 1'b1;
                    if (a_prot) begin
                        next_s.perr = 1'b1;
                    end else begin
                        // changes gather in the page buffer
                        if (a_page != s.pb_page) begin
                            next_s.pb_page = a_page;
                            next_s.pb = '1;
                        end
                        unique case (cfg_width_i)
                            UFBC_W8: next_s.pb[wbit +: 8] = wdata_i[7:0];
                            UFBC_W16: next_s.pb[wbit +: 16] = wdata_i[15:0];
                            default: next_s.pb[wbit +: 32] = wdata_i;
                        endcase
                    end
                end else if ((acc && cmd_i == UFBC_PROGRAM) ||
                             (ce_i && !acc && jtag_prog_i)) begin
                    if (pb_prot) begin
                        next_s.perr = 1'b1;
                        next_s.ack = 1'b1;
                    end else begin
                        next_s.st = UFBC_PROG;
                        next_s.busy = 1'b1;
                        next_s.pidx = 3'h0;
                        next_s.bb_valid = 1'b0;
                    end
                end
            end
            UFBC_RWAIT: begin
                if (s.cnt == 2'h0) begin
                    next_s.st = UFBC_IDLE;
                    next_s.busy = 1'b0;
                    next_s.ack = 1'b1;
                    next_s.sec = dec[129];
                    next_s.ded = dec[128];
                    next_s.bb_data = dec[127:0];
                    next_s.bb_tag = s.rblk;
                    next_s.bb_valid = 1'b1;
                    next_s.rdata = ufbc_lane(dec[127:0], s.roff,
                        cfg_width_i);
                end else begin
                    next_s.cnt = 2'(s.cnt - 2'h1);
                end
            end
            UFBC_PROG: begin
                // one block of the page per cycle
                next_s.pidx = 3'(s.pidx + 3'h1);
                if (s.pidx == 3'h7) begin
                    next_s.st = UFBC_IDLE;
                    next_s.busy = 1'b0;
                    next_s.ack = 1'b1;
                    next_s.jptr = 5'h00;
                end
            end
            default: begin
                next_s.st = UFBC_IDLE;
                next_s.busy = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register, frozen while ce_i is low
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.pb <= '1;
            s.ks <= `UFBC_KEY_RST;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // array write with fresh check bits
    always_ff @(posedge mclk_i) begin
        if (ce_i && s.st == UFBC_PROG) begin
            mem[{s.pb_page, s.pidx}] <= {ufbc_gen(s.pb[{s.pidx, 7'h00}
                +: 128]), s.pb[{s.pidx, 7'h00} +: 128]};
        end
    end

    // outputs straight from the state register
    assign rdata_o = s.rdata;
    assign ack_o = s.ack;
    assign sec_o = s.sec;
    assign ded_o = s.ded;
    assign perr_o = s.perr;
    assign busy_o = s.busy;

    ////////////////////////////////////////////////////////////////////
    a_rand_read: assert property (@(posedge mclk_i)
        disable iff (rst_i || !ce_i)
        acc && cmd_i == UFBC_READ && in_range && !(ahead_en_i && hit)
        |=> busy_o && !ack_o ##1 busy_o && !ack_o ##1 ack_o && !busy_o)
        else $error("random read latency wrong");
    a_ahead_read: assert property (@(posedge mclk_i)
        disable iff (rst_i || !ce_i)
        acc && cmd_i == UFBC_READ && in_range && ahead_en_i && hit
        |=> ack_o && !busy_o)
        else $error("read-ahead not served next cycle");
    a_buf_fill: assert property (@(posedge mclk_i)
        disable iff (rst_i || !ce_i)
        acc && cmd_i == UFBC_READ && in_range && !(ahead_en_i && hit)
        |-> ##3 (s.bb_valid && s.bb_tag == $past(a_blk, 3)))
        else $error("block buffer not loaded");
    a_prog_len: assert property (@(posedge mclk_i)
        disable iff (rst_i || !ce_i)
        acc && cmd_i == UFBC_PROGRAM && !pb_prot
        |=> busy_o [*8] ##1 (!busy_o && ack_o))
        else $error("page program length wrong");
    a_prot_reject: assert property (@(posedge mclk_i)
        disable iff (rst_i || !ce_i)
        acc && (cmd_i == UFBC_PROGRAM ? pb_prot : (cmd_i == UFBC_WRITE
        && in_range && a_prot)) |=> perr_o && !busy_o && $stable(s.pb))
        else $error("protected change not refused");
    a_addr_range: assert property (@(posedge mclk_i)
        disable iff (rst_i || !ce_i)
        acc && cmd_i != UFBC_PROGRAM && !in_range |=> perr_o && ack_o)
        else $error("out of range address not refused");
    a_err_flags: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        (sec_o || ded_o) |-> ack_o && !(sec_o && ded_o))
        else $error("error flags without data or both set");
    a_width_read: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        ack_o && !perr_o && cfg_width_i == UFBC_W8
        |-> rdata_o[31:8] == 24'h00_0000)
        else $error("byte read wider than a byte");
    a_jtag_ptr: assert property (@(posedge mclk_i)
        disable iff (rst_i || !ce_i)
        jtag_load_i && s.st == UFBC_IDLE
        |=> s.jptr == 5'($past(s.jptr) + 5'h01))
        else $error("serial word pointer did not advance");
endmodule // ufbc_top

// *** test/ufbc_fabric_model.sv ***
`timescale 1ns/1ps
module ufbc_fabric_model (
    input wire logic mclk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdata_i,
    input wire logic sec_i,
    input wire logic ded_i,
    input wire logic perr_i,
    output logic req_o,
    output ufbc_pkg::ufbc_cmd_t cmd_o,
    output logic [18:0] addr_o,
    output logic [31:0] wdata_o
);
    import ufbc_pkg::*;
    ////////////////////////////////////////////////////////////////////
    // idle lines at time zero
    initial begin
        req_o = 1'b0;
        cmd_o = UFBC_NOP;
        addr_o = 19'h0_0000;
        wdata_o = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////////
    // one request: strobe for the take edge, then wait for the answer
    task automatic xfer(input ufbc_cmd_t c, input logic [18:0] a,
        input logic [31:0] d, output int cyc, output logic [31:0] rd,
        output logic [2:0] fl);
        @(posedge mclk_i);
        #1;
        req_o = 1'b1;
        cmd_o = c;
        addr_o = a;
        wdata_o = d;
        @(posedge mclk_i);
        #1;
        // released lines flip so stale values never look valid
        req_o = 1'b0;
        cmd_o = UFBC_NOP;
        addr_o = ~a;
        wdata_o = ~d;
        cyc = 1;
        // bounded wait, up to 20 cycles, for the answer
        while (ack_i !== 1'b1 && cyc < 20) begin
            @(posedge mclk_i);
            #1;
            cyc++;
        end
        rd = rdata_i;
        fl = {sec_i, ded_i, perr_i};
    endtask
endmodule // ufbc_fabric_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "ufbc_regs.svh"
module tb_top;
    import ufbc_pkg::*;
    logic mclk, rst, ce, ahead, pall, jtdi, jsh, jld, jenc, jprog;
    logic req, ack, sec, ded, perr, busy;
    ufbc_width_t wid;
    ufbc_cmd_t cmd;
    logic [63:0] psec;
    logic [11:0] jpage;
    logic [18:0] addr;
    logic [31:0] wdata, rdata;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 32'h05a7;
    logic [7:0] mem[int]; // programmed array bytes
    logic [7:0] pbuf[128]; // page buffer mirror
    int pb_page = -1;
    int lblk = -1; // block held by the block buffer
    ufbc_top u_ufbc_top (.mclk_i(mclk), .rst_i(rst), .ce_i(ce),
        .cfg_width_i(wid), .ahead_en_i(ahead), .prot_all_i(pall),
        .prot_sec_i(psec), .req_i(req), .cmd_i(cmd), .addr_i(addr),
        .wdata_i(wdata), .jtag_tdi_i(jtdi), .jtag_shift_i(jsh),
        .jtag_load_i(jld), .jtag_enc_i(jenc), .jtag_page_i(jpage),
        .jtag_prog_i(jprog), .rdata_o(rdata), .ack_o(ack), .sec_o(sec),
        .ded_o(ded), .perr_o(perr), .busy_o(busy));
    ufbc_fabric_model u_ufbc_fabric_model (.mclk_i(mclk), .ack_i(ack),
        .rdata_i(rdata), .sec_i(sec), .ded_i(ded), .perr_i(perr),
        .req_o(req), .cmd_o(cmd), .addr_o(addr), .wdata_o(wdata));
    ////////////////////////////////////////////////////////////////////
    // 40 mhz clock
    always #12.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // model: write into page buffer, retag fills erased ones
    function automatic void m_wr(int a, logic [31:0] d);
        int n = 1 << int'(wid);
        int b = (a & ~(n - 1)) & 127;
        if ((a >> 7) != pb_page) begin
            foreach (pbuf[i]) pbuf[i] = 8'hff;
            pb_page = a >> 7;
        end
        for (int i = 0; i < n; i++) pbuf[b + i] = d[8*i +: 8];
    endfunction
    // model: aligned little endian read, zero extended
    function automatic logic [31:0] m_rd(int a);
        int n = 1 << int'(wid);
        int b = a & ~(n - 1);
        logic [31:0] r = 32'h0000_0000;
        for (int i = 0; i < n; i++) r[8*i +: 8] = mem[b + i];
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////
    // request with expected latency and flags {sec, ded, perr}
    task automatic op(input ufbc_cmd_t c, input int a, input logic [31:0] d,
        input int lat, input logic [2:0] fe, output logic [31:0] rd);
        int cyc;
        logic [2:0] fl;
        u_ufbc_fabric_model.xfer(c, a[18:0], d, cyc, rd, fl);
        check(cyc, lat, "latency");
        check({29'h0, fl}, {29'h0, fe}, "flags");
        check({31'h0, busy}, 32'h0000_0000, "busy at answer");
    endtask
    // read, latency from block buffer state
    task automatic rd_chk(input int a);
        logic [31:0] rd;
        int hit = (ahead && (a >> 4) == lblk);
        op(UFBC_READ, a, 0, hit ? 1 : 3, 3'b000, rd);
        check(rd, m_rd(a), "read data");
        lblk = a >> 4;
    endtask
    // program whole buffered page and mirror it
    task automatic prog_page();
        logic [31:0] rd;
        op(UFBC_PROGRAM, pb_page << 7, 0, 9, 3'b000, rd);
        for (int i = 0; i < 128; i++) mem[pb_page * 128 + i] = pbuf[i];
        lblk = -1;
    endtask
    // serial word, msb first, then load pulse
    task automatic jword(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            jtdi = w[i];
            jsh = 1'b1;
            @(posedge mclk);
            #1;
        end
        jsh = 1'b0;
        jld = 1'b1;
        @(posedge mclk);
        #1;
        jld = 1'b0;
    endtask
    // serial program pulse, bounded wait for answer
    task automatic jrun();
        int cyc = 1;
        jprog = 1'b1;
        @(posedge mclk);
        #1;
        jprog = 1'b0;
        while (ack !== 1'b1 && cyc < 20) begin
            @(posedge mclk);
            #1;
            cyc++;
        end
        check(cyc, 9, "serial program latency");
        check({31'h0, perr}, 32'h0000_0000, "serial refusal");
        lblk = -1;
        pb_page = -1;
    endtask
    ////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int a[8];
        int pg;
        logic [31:0] d, rd, jw[32];
        {mclk, ce, ahead, pall, jtdi, jsh, jld, jenc, jprog} = 9'h000;
        rst = 1'b1;
        wid = UFBC_W32;
        psec = 64'h0;
        jpage = 12'h000;
        ce = 1'b1;
        mclk = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        // every width: write, program, read miss then hits
        for (int w = 0; w < 3; w++) begin
            wid = ufbc_width_t'(w);
            ahead = 1'b0;
            pg = $unsigned($random(seed)) % 2112;
            if (pg == pb_page) pg = (pg + 1) % 2112;
            for (int k = 0; k < 8; k++) begin
                a[k] = (pg << 7) | ($unsigned($random(seed)) & 127);
                d = $random(seed);
                if (k < 4) op(UFBC_WRITE, a[k], d, 1, 3'b000, rd);
                if (k < 4) m_wr(a[k], d);
            end
            prog_page();
            for (int k = 0; k < 8; k++) rd_chk(a[k]);
            ahead = 1'b1;
            for (int k = 0; k < 8; k++) rd_chk(a[k / 2]);
            $display("test width %0d done", w);
        end
        // out of range page refused
        op(UFBC_READ, 2112 << 7, 0, 1, 3'b001, rd);
        op(UFBC_WRITE, 2112 << 7, 0, 1, 3'b001, rd);
        // sector and whole block protection
        psec[5] = 1'b1;
        op(UFBC_WRITE, 167 << 7, 0, 1, 3'b001, rd);
        psec = 64'h0;
        pall = 1'b1;
        op(UFBC_WRITE, 10 << 7, 0, 1, 3'b001, rd);
        pall = 1'b0;
        op(UFBC_WRITE, 167 << 7, 0, 1, 3'b000, rd);
        psec[5] = 1'b1;
        op(UFBC_PROGRAM, 167 << 7, 0, 1, 3'b001, rd);
        psec = 64'h0;
        pb_page = -1;
        $display("test protection done");
        // serial path, plain words, full page
        wid = UFBC_W32;
        ahead = 1'b0;
        jpage = 12'd700;
        for (int n = 0; n < 32; n++) begin
            jw[n] = $random(seed);
            jword(jw[n]);
            for (int i = 0; i < 4; i++) begin
                mem[700 * 128 + 4 * n + i] = jw[n][8*i +: 8];
            end
        end
        jrun();
        for (int n = 0; n < 32; n++) rd_chk(700 * 128 + 4 * n);
        // serial path, encrypted first word after pointer reset
        jenc = 1'b1;
        jpage = 12'd900;
        d = $random(seed);
        jword(d ^ `UFBC_KEY_RST);
        for (int i = 0; i < 4; i++) mem[900 * 128 + i] = d[8*i +: 8];
        jrun();
        rd_chk(900 * 128);
        jenc = 1'b0;
        $display("test serial done");
        report_and_stop();
    end
endmodule // tb_top
